// ==== rom_loader_defines.vh ====
// timing counts, command framing and word layout for the serial rom id loader
`ifndef ROM_LOADER_DEFINES_VH
`define ROM_LOADER_DEFINES_VH

// ****************************************************************
// clock and serial timing
// ****************************************************************
`define REF_CLK_MHZ 100
// half period of the serial clock, in ns
`define ROM_SCLK_HALF_NS 80
// half period in ref_clk cycles, rounded up, never below one
`define ROM_HALF_CYC (((`ROM_SCLK_HALF_NS * `REF_CLK_MHZ) + 999) / 1000)
`define ROM_DIV_W 8

// ****************************************************************
// command framing
// ****************************************************************
`define ROM_START_BIT 1'h1
`define ROM_READ_OP 2'h2
`define ROM_START_ADDR 5'h00
`define ROM_CMD_BITS 8
`define ROM_CMD_LAST 4'h7

// ****************************************************************
// word layout
// ****************************************************************
`define ROM_WORD_BITS 16
`define ROM_BIT_LAST 4'hf
`define ROM_IDX_ZERO 2'h0
`define ROM_IDX_VID 2'h1
`define ROM_IDX_PID 2'h2
`define ROM_STREAM_W 18

// ****************************************************************
// strap settling
// ****************************************************************
`define STRAP_SETTLE_LAST 4'h7

`endif

// ==== rom_clk_div.v ====
// half-period tick divider for the serial rom clock
`timescale 1ns/1ns
`include "rom_loader_defines.vh"

module rom_clk_div
(
   input wire ref_clk, // core clock
   input wire rst_n, // synchronous reset, active low
   input wire run, // count while high, restart when low
   output reg tick_ff // one-cycle pulse per half period
);

   localparam [31:0] HALF_LAST_W = `ROM_HALF_CYC - 1;
   localparam [`ROM_DIV_W-1:0] HALF_LAST = HALF_LAST_W[`ROM_DIV_W-1:0];

   reg [`ROM_DIV_W-1:0] cnt_ff;

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cnt_ff <= {`ROM_DIV_W{1'b0}};
         tick_ff <= 1'b0;
      end
      else if (!run)
      begin
         cnt_ff <= {`ROM_DIV_W{1'b0}};
         tick_ff <= 1'b0;
      end
      else if (cnt_ff == HALF_LAST)
      begin
         cnt_ff <= {`ROM_DIV_W{1'b0}};
         tick_ff <= 1'b1;
      end
      else
      begin
         cnt_ff <= cnt_ff + 8'h01;
         tick_ff <= 1'b0;
      end
   end

endmodule

// ==== word_fifo2.v ====
// two-entry buffer with registered head, valid and ready on both sides
`timescale 1ns/1ns

module word_fifo2
#(
   parameter WIDTH = 18
)
(
   input wire ref_clk, // core clock
   input wire rst_n, // synchronous reset, active low
   input wire in_valid, // word offered
   output wire in_ready, // buffer has room
   input wire [WIDTH-1:0] in_data, // offered word
   output reg out_valid_ff, // head word valid
   input wire out_ready, // receiver takes head word
   output reg [WIDTH-1:0] out_data_ff // head word
);

   reg [WIDTH-1:0] tail_ff;
   reg tail_valid_ff;
   wire push;
   wire pop;

   assign in_ready = !tail_valid_ff;
   assign push = in_valid && in_ready;
   assign pop = out_valid_ff && out_ready;

   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         out_valid_ff <= 1'b0;
         out_data_ff <= {WIDTH{1'b0}};
         tail_ff <= {WIDTH{1'b0}};
         tail_valid_ff <= 1'b0;
      end
      else if (pop)
      begin
         if (tail_valid_ff)
         begin
            out_data_ff <= tail_ff;
            tail_valid_ff <= 1'b0;
         end
         else if (push)
         begin
            out_data_ff <= in_data;
         end
         else
         begin
            out_valid_ff <= 1'b0;
         end
      end
      else if (push)
      begin
         if (!out_valid_ff)
         begin
            out_data_ff <= in_data;
            out_valid_ff <= 1'b1;
         end
         else
         begin
            tail_ff <= in_data;
            tail_valid_ff <= 1'b1;
         end
      end
   end

endmodule

// ==== serial_rom_id_loader.v ====
// power-up loader that reads vendor and product ids from a three-wire serial rom
`timescale 1ns/1ns
`include "rom_loader_defines.vh"

// Notes on behaviour
// - strap low enables the rom interface and turns pull-downs on both pins on.
// - strap high disables the rom interface and turns both pull-downs off.
// - rom holds word 0 zero, word 1 vendor id, word 2 product id.
// - after reset, with strap low, exactly one read sequence, then nothing more.
// - send start bit 1, read opcode 10, then address 00000.
// - after the address the data line is released and the rom drives it.
// - this block makes the serial clock; rom changes data on rising edges.
// - after the third word both pins float, held low by the pull-downs.
module serial_rom_id_loader
#(
   // default ids; values are arbitrary
   parameter [15:0] DEFAULT_VENDOR_ID = 16'h1234,
   parameter [15:0] DEFAULT_PRODUCT_ID = 16'h5678
)
(
   input wire ref_clk, // core clock, 100 MHz
   input wire rst_n, // synchronous power-on reset, active low
   input wire ext_rom_disable_strap, // strap pin, high disables the rom
   output reg rom_serial_clock_ff, // serial clock pin output
   output reg rom_serial_clock_oe_n_ff, // serial clock drive enable, low drives
   output reg rom_serial_io_out_ff, // data pin output value
   output reg rom_serial_io_oe_n_ff, // data pin drive enable, low drives
   input wire rom_serial_io_in, // data pin input
   output reg rom_pulldown_en_ff, // weak pull-downs on both pins
   output reg [15:0] vendor_id_ff, // reported vendor id
   output reg [15:0] product_id_ff, // reported product id
   output reg ids_valid_ff, // ids are final
   output reg load_done_ff, // loader finished, interface released
   output wire word_valid, // received word available
   input wire word_ready, // receiver takes the word
   output wire [`ROM_STREAM_W-1:0] word_data // word index and word
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [2:0] ST_STRAP = 3'h0;
   localparam [2:0] ST_SEND = 3'h1;
   localparam [2:0] ST_RECV = 3'h2;
   localparam [2:0] ST_DONE = 3'h3;
   localparam [2:0] ST_OFF = 3'h4;

   // start bit, read opcode and first word address, sent msb first
   localparam [`ROM_CMD_BITS-1:0] CMD_WORD = {`ROM_START_BIT, `ROM_READ_OP, `ROM_START_ADDR};

   reg [2:0] state_ff;
   // bit 1 carries the strap pin, bit 0 the data pin
   reg [1:0] pin_s1_ff;
   reg [1:0] pin_s2_ff;
   reg [1:0] pin_s3_ff;
   reg io_val_ff;
   reg [3:0] settle_ff;
   reg [3:0] bit_cnt_ff;
   reg [`ROM_CMD_BITS-1:0] cmd_sr_ff;
   reg [15:0] shift_ff;
   reg [1:0] word_idx_ff;
   reg pending_ff;
   reg [`ROM_STREAM_W-1:0] pend_data_ff;

   wire tick;
   wire fifo_in_ready;
   wire active;
   wire stall;
   wire falling;
   wire [15:0] word_now;
   wire [1:0] pin_raw;

   // ****************************************************************
   // state decoding
   // ****************************************************************
   // true while the serial clock has bits to move
   function in_transfer;
      input [2:0] st;
      begin
         in_transfer = (st == ST_SEND) || (st == ST_RECV);
      end
   endfunction

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   assign pin_raw = {ext_rom_disable_strap, rom_serial_io_in};

   // three flops per pin; only the second flop reads the first
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_sync
         always @(posedge ref_clk)
         begin
            if (!rst_n)
            begin
               pin_s1_ff[gi] <= 1'b0;
               pin_s2_ff[gi] <= 1'b0;
               pin_s3_ff[gi] <= 1'b0;
            end
            else
            begin
               pin_s1_ff[gi] <= pin_raw[gi];
               pin_s2_ff[gi] <= pin_s1_ff[gi];
               pin_s3_ff[gi] <= pin_s2_ff[gi];
            end
         end
      end
   endgenerate

   // data level counts once flops two and three agree
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         io_val_ff <= 1'b0;
      end
      else if (pin_s2_ff[0] == pin_s3_ff[0])
      begin
         io_val_ff <= pin_s3_ff[0];
      end
   end

   // ****************************************************************
   // serial clock divider and back-pressure
   // ****************************************************************
   // hold the clock low while a finished word cannot enter the buffer
   // no bit is lost: the rom only moves on a rising edge, which waits here
   assign active = in_transfer(state_ff);
   assign stall = pending_ff && !fifo_in_ready && !rom_serial_clock_ff;
   assign falling = tick && rom_serial_clock_ff && in_transfer(state_ff);
   assign word_now = {shift_ff[14:0], io_val_ff};

   rom_clk_div u_div
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(active && !stall),
      .tick_ff(tick)
   );

   // ****************************************************************
   // word buffer toward the receiver
   // ****************************************************************
   word_fifo2 #(.WIDTH(`ROM_STREAM_W)) u_fifo
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .in_valid(pending_ff),
      .in_ready(fifo_in_ready),
      .in_data(pend_data_ff),
      .out_valid_ff(word_valid),
      .out_ready(word_ready),
      .out_data_ff(word_data)
   );

   // ****************************************************************
   // read sequencer
   // ****************************************************************
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_STRAP;
         settle_ff <= 4'h0;
         bit_cnt_ff <= 4'h0;
         cmd_sr_ff <= {`ROM_CMD_BITS{1'b0}};
         shift_ff <= 16'h0000;
         word_idx_ff <= `ROM_IDX_ZERO;
         pending_ff <= 1'b0;
         pend_data_ff <= {`ROM_STREAM_W{1'b0}};
         rom_serial_clock_ff <= 1'b0;
         rom_serial_clock_oe_n_ff <= 1'b1;
         rom_serial_io_out_ff <= 1'b0;
         rom_serial_io_oe_n_ff <= 1'b1;
         rom_pulldown_en_ff <= 1'b0;
         vendor_id_ff <= DEFAULT_VENDOR_ID;
         product_id_ff <= DEFAULT_PRODUCT_ID;
         ids_valid_ff <= 1'b0;
         load_done_ff <= 1'b0;
      end
      else
      begin
         if (pending_ff && fifo_in_ready)
         begin
            pending_ff <= 1'b0;
         end
         case (state_ff)
            ST_STRAP:
            begin
               // the strap counts once it has agreed for eight cycles
               if (pin_s2_ff[1] != pin_s3_ff[1])
               begin
                  settle_ff <= 4'h0;
               end
               else if (settle_ff != `STRAP_SETTLE_LAST)
               begin
                  settle_ff <= settle_ff + 4'h1;
               end
               else if (!pin_s3_ff[1])
               begin
                  // one read only, from here on
                  state_ff <= ST_SEND;
                  rom_pulldown_en_ff <= 1'b1;
                  rom_serial_clock_oe_n_ff <= 1'b0;
                  rom_serial_io_oe_n_ff <= 1'b0;
                  rom_serial_io_out_ff <= CMD_WORD[`ROM_CMD_BITS-1];
                  cmd_sr_ff <= {CMD_WORD[`ROM_CMD_BITS-2:0], 1'b0};
                  bit_cnt_ff <= 4'h0;
               end
               else
               begin
                  state_ff <= ST_OFF;
                  rom_pulldown_en_ff <= 1'b0;
                  ids_valid_ff <= 1'b1;
                  load_done_ff <= 1'b1;
               end
            end
            ST_SEND:
            begin
               if (tick)
               begin
                  // rising edge lets the rom take the bit that stands
                  rom_serial_clock_ff <= !rom_serial_clock_ff;
               end
               if (falling)
               begin
                  if (bit_cnt_ff == `ROM_CMD_LAST)
                  begin
                     // dummy bit now on the line, ignored
                     rom_serial_io_oe_n_ff <= 1'b1;
                     state_ff <= ST_RECV;
                     bit_cnt_ff <= 4'h0;
                  end
                  else
                  begin
                     rom_serial_io_out_ff <= cmd_sr_ff[`ROM_CMD_BITS-1];
                     cmd_sr_ff <= {cmd_sr_ff[`ROM_CMD_BITS-2:0], 1'b0};
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  end
               end
            end
            ST_RECV:
            begin
               if (tick)
               begin
                  rom_serial_clock_ff <= !rom_serial_clock_ff;
               end
               if (falling)
               begin
                  // sample half a period after the rom's rising-edge change
                  shift_ff <= word_now;
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
                  if (bit_cnt_ff == `ROM_BIT_LAST)
                  begin
                     pending_ff <= 1'b1;
                     pend_data_ff <= {word_idx_ff, word_now};
                     // address advances inside the rom, none sent again
                     word_idx_ff <= word_idx_ff + 2'h1;
                     if (word_idx_ff == `ROM_IDX_VID)
                     begin
                        vendor_id_ff <= word_now;
                     end
                     if (word_idx_ff == `ROM_IDX_PID)
                     begin
                        product_id_ff <= word_now;
                        ids_valid_ff <= 1'b1;
                        state_ff <= ST_DONE;
                     end
                  end
               end
            end
            ST_DONE:
            begin
               // pins float, pull-downs keep them low
               rom_serial_clock_ff <= 1'b0;
               rom_serial_clock_oe_n_ff <= 1'b1;
               rom_serial_io_oe_n_ff <= 1'b1;
               rom_serial_io_out_ff <= 1'b0;
               load_done_ff <= 1'b1;
            end
            ST_OFF:
            begin
               // pins stay released, default ids stand
               rom_serial_clock_ff <= 1'b0;
               rom_serial_io_out_ff <= 1'b0;
               rom_serial_clock_oe_n_ff <= 1'b1;
               rom_serial_io_oe_n_ff <= 1'b1;
            end
            default:
            begin
               // unused codes fall back to the released state
               state_ff <= ST_DONE;
            end
         endcase
      end
   end

endmodule

// ==== rom_loader_chk_asserts.sv ====
// port checks for the serial rom id loader
`timescale 1ns/1ns
`include "rom_loader_defines.vh"
module rom_loader_chk
#(
   parameter [15:0] DEFAULT_VENDOR_ID = 16'h1234,
   parameter [15:0] DEFAULT_PRODUCT_ID = 16'h5678
)
(
   input wire ref_clk, // clock
   input wire rst_n, // reset
   input wire ext_rom_disable_strap, // strap
   input wire rom_serial_clock_ff, // sclk
   input wire rom_serial_clock_oe_n_ff, // sclk enable
   input wire rom_serial_io_out_ff, // io out
   input wire rom_serial_io_oe_n_ff, // io enable
   input wire rom_serial_io_in, // io in
   input wire rom_pulldown_en_ff, // pull-downs
   input wire [15:0] vendor_id_ff, // vendor
   input wire [15:0] product_id_ff, // product
   input wire ids_valid_ff, // ids final
   input wire load_done_ff, // done
   input wire word_valid, // word valid
   input wire word_ready, // word ready
   input wire [`ROM_STREAM_W-1:0] word_data // word
);
   // ********
   // rising edges of the serial clock
   // ********
   reg clk_d_ff;
   reg [5:0] rise_cnt_ff;
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         clk_d_ff <= 1'h0;
         rise_cnt_ff <= 6'h00;
      end
      else
      begin
         clk_d_ff <= rom_serial_clock_ff;
         if (rom_serial_clock_ff && !clk_d_ff)
            rise_cnt_ff <= rise_cnt_ff + 6'h01;
      end
   end
   default clocking chk_cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ********
   // assertions
   // ********
   pd_on_drive_a: assert property ($fell(rom_serial_clock_oe_n_ff) |-> rom_pulldown_en_ff
      && !rom_serial_io_oe_n_ff && !ext_rom_disable_strap) else $error("drive without pull-down");
   pd_off_float_a: assert property (!rom_pulldown_en_ff |-> rom_serial_clock_oe_n_ff
      && rom_serial_io_oe_n_ff) else $error("pins driven while disabled");
   start_bit_a: assert property ($fell(rom_serial_io_oe_n_ff) |-> rom_serial_io_out_ff
      && !rom_serial_clock_ff) else $error("first data bit not one");
   cmd_len_a: assert property ($rose(rom_serial_io_oe_n_ff) && !rom_serial_clock_oe_n_ff
      |-> rise_cnt_ff == 6'h08 && !rom_serial_clock_ff) else $error("release not after 8 bits");
   hi_phase_a: assert property ($rose(rom_serial_clock_ff) |-> rom_serial_clock_ff[*8]
      ##1 !rom_serial_clock_ff) else $error("clock high phase not 8 cycles");
   data_low_a: assert property ($changed(rom_serial_io_out_ff) && !rom_serial_io_oe_n_ff
      |-> !rom_serial_clock_ff) else $error("data changed while clock high");
   one_read_a: assert property ($rose(load_done_ff) && rom_pulldown_en_ff
      |-> rise_cnt_ff == 6'h38) else $error("read not 56 clocks");
   float_done_a: assert property ($rose(load_done_ff) |-> rom_serial_clock_oe_n_ff
      && rom_serial_io_oe_n_ff) else $error("pins still driven at done");
   quiet_after_a: assert property (load_done_ff |=> load_done_ff && rom_serial_clock_oe_n_ff
      && $stable(rom_serial_clock_ff)) else $error("activity after done");
   default_id_a: assert property (ids_valid_ff && !rom_pulldown_en_ff |->
      vendor_id_ff == DEFAULT_VENDOR_ID && product_id_ff == DEFAULT_PRODUCT_ID)
      else $error("default ids wrong");
   word_hold_a: assert property (word_valid && !word_ready |=> word_valid
      && $stable(word_data)) else $error("stalled word lost");
endmodule

bind serial_rom_id_loader rom_loader_chk #(.DEFAULT_VENDOR_ID(DEFAULT_VENDOR_ID),
   .DEFAULT_PRODUCT_ID(DEFAULT_PRODUCT_ID)) u_chk (.ref_clk, .rst_n, .ext_rom_disable_strap,
   .rom_serial_clock_ff, .rom_serial_clock_oe_n_ff, .rom_serial_io_out_ff,
   .rom_serial_io_oe_n_ff, .rom_serial_io_in, .rom_pulldown_en_ff, .vendor_id_ff,
   .product_id_ff, .ids_valid_ff, .load_done_ff, .word_valid, .word_ready, .word_data);

// ==== rom_model.sv ====
// serial three-wire rom with auto-incrementing word address
`timescale 1ns/1ns
module rom_model
(
   input wire sclk, // serial clock at the rom
   input wire cs, // chip select
   input wire din, // data line level
   input wire [47:0] image, // words 0..2, word 0 on top
   input wire [6:0] lag_ns, // output delay after rise
   output reg q_oe, // rom drives data line
   output reg q, // rom data
   output reg [7:0] cmd, // command bits taken
   output reg [6:0] edges // rising edges taken
);
   initial {q, cmd, edges} = 16'h0000;
   initial q_oe = 1'h0;
   always @(posedge sclk or negedge cs)
   begin
      if (!cs)
      begin
         {q, cmd, edges} <= 16'h0000;
      end
      else
      begin
         edges <= edges + 7'h01;
         if (edges < 7'h08)
            cmd <= {cmd[6:0], din};
         if (edges == 7'h07)
            q <= #(lag_ns) 1'h0;
         else if (edges > 7'h07 && edges < 7'h38)
            q <= #(lag_ns) image[7'h37 - edges];
      end
   end
   // takes the line once the device lets go of it
   always @(negedge sclk or negedge cs)
      if (!cs)
         q_oe <= 1'h0;
      else if (edges == 7'h08)
         q_oe <= 1'h1;
endmodule

// ==== tb_serial_rom_id_loader.sv ====
// self-checking bench for the serial rom id loader
`timescale 1ns/1ns
`include "rom_loader_defines.vh"
module tb_serial_rom_id_loader;
   localparam [15:0] VID0 = 16'h1234;
   localparam [15:0] PID0 = 16'h5678;
   reg ref_clk = 1'h0;
   reg rst_n = 1'h0;
   reg ext_rom_disable_strap = 1'h0;
   reg word_ready = 1'h0;
   reg [6:0] lag_ns = 7'h05;
   reg [47:0] image = 48'h0;
   wire rom_serial_clock_ff, rom_serial_clock_oe_n_ff, rom_serial_io_out_ff;
   wire rom_serial_io_oe_n_ff, rom_pulldown_en_ff, ids_valid_ff, load_done_ff;
   wire word_valid, q_oe, q, rom_serial_io_in, sclk_pin;
   wire [15:0] vendor_id_ff, product_id_ff;
   wire [17:0] word_data;
   wire [7:0] cmd;
   wire [6:0] edges;
   integer n_mismatch = 0;
   integer check_count = 0;
   logic [17:0] got[$];

   always #5 ref_clk = ~ref_clk;
   assign sclk_pin = !rom_serial_clock_oe_n_ff ? rom_serial_clock_ff : 1'h0;
   // a released line sits low on the pull-down, else floats high
   assign rom_serial_io_in = !rom_serial_io_oe_n_ff ? rom_serial_io_out_ff :
      q_oe ? q : !rom_pulldown_en_ff;

   serial_rom_id_loader #(.DEFAULT_VENDOR_ID(VID0), .DEFAULT_PRODUCT_ID(PID0)) u_dut (
      .ref_clk, .rst_n, .ext_rom_disable_strap, .rom_serial_clock_ff,
      .rom_serial_clock_oe_n_ff, .rom_serial_io_out_ff, .rom_serial_io_oe_n_ff,
      .rom_serial_io_in, .rom_pulldown_en_ff, .vendor_id_ff, .product_id_ff,
      .ids_valid_ff, .load_done_ff, .word_valid, .word_ready, .word_data);
   rom_model u_rom (.sclk(sclk_pin), .cs(rst_n), .din(rom_serial_io_in), .image, .lag_ns,
      .q_oe, .q, .cmd, .edges);

   always @(posedge ref_clk)
      if (word_valid === 1'h1 && word_ready === 1'h1)
         got.push_back(word_data);

   // ********
   // helpers
   // ********
   task check(input string what, input [63:0] seen, input [63:0] exp);
      check_count = check_count + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task start(input strap);
      @(posedge ref_clk);
      rst_n <= 1'h0;
      ext_rom_disable_strap <= strap;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'h1;
      got.delete();
   endtask
   task wait_done;
      integer i;
      for (i = 0; i < 3000 && load_done_ff !== 1'h1; i = i + 1)
         @(posedge ref_clk) #1;
      if (load_done_ff !== 1'h1)
      begin
         check("load_done", load_done_ff, 1'h1);
         tally_and_finish;
      end
   endtask
   // ********
   // scenarios
   // ********
   task t_off;
      start(1'h1);
      wait_done;
      check("ids_valid", ids_valid_ff, 1'h1);
      check("vendor", vendor_id_ff, VID0);
      check("product", product_id_ff, PID0);
      check("pulldown", rom_pulldown_en_ff, 1'h0);
      check("drive", {rom_serial_clock_oe_n_ff, rom_serial_io_oe_n_ff}, 2'h3);
      check("edges", edges, 7'h00);
      check("words", got.size(), 0);
      $display("test off done");
   endtask
   task t_read(input [47:0] img, input [6:0] lag, input rdy);
      integer i, k;
      start(1'h0);
      image <= img;
      lag_ns <= lag;
      word_ready <= rdy;
      for (i = 0; i < 100 && rom_serial_clock_oe_n_ff !== 1'h0; i = i + 1)
         @(posedge ref_clk) #1;
      if (rom_serial_clock_oe_n_ff !== 1'h0)
      begin
         check("drive start", rom_serial_clock_oe_n_ff, 1'h0);
         tally_and_finish;
      end
      check("pulldown", rom_pulldown_en_ff, 1'h1);
      check("start bit", rom_serial_io_out_ff, 1'h1);
      wait_done;
      if (!rdy)
      begin
         check("held", word_valid, 1'h1);
         check("early pops", got.size(), 0);
         repeat (50) @(posedge ref_clk);
         word_ready <= 1'h1;
      end
      repeat (10) @(posedge ref_clk) #1;
      check("drained", word_valid, 1'h0);
      check("words", got.size(), 3);
      for (k = 0; k < 3 && k < got.size(); k = k + 1)
         check("word", got[k], {k[1:0], img[47 - 16 * k -: 16]});
      check("command", cmd, 8'hc0);
      check("edges", edges, 7'h38);
      check("vendor", vendor_id_ff, img[31:16]);
      check("product", product_id_ff, img[15:0]);
      check("release", {rom_serial_clock_oe_n_ff, rom_serial_io_oe_n_ff}, 2'h3);
      check("pulldown kept", rom_pulldown_en_ff, 1'h1);
      repeat (200) @(posedge ref_clk) #1;
      check("no more edges", edges, 7'h38);
      $display("test read done");
   endtask

   initial
   begin
      t_off;
      t_read(48'h0000_a5c3_3c5a, 7'h05, 1'h1);
      t_read(48'h0000_ffff_8001, 7'h19, 1'h0);
      tally_and_finish;
   end
endmodule
